//--- src/mps_selector.sv
// Contract
// - stepping time-out mode applies after inactivity
// - stepping confirm missed: discard, alarm 3s
// - stepping confirm edge applies; only confirm mode
// - word decoded binary, bit2 most significant
// - zero word is rest, no action
// - word time-out mode applies after stability
// - word confirm mode applies on confirm edge
// - stepping and word paths lock each other
// - word confirm missed: reject, alarm 3s
// - separate confirms; word window from word activity
// - restore: reload, out of range gives 0+alarm
// - sync: hold 0, alarm two cycles, adopt word
// - sync with zero/bad word: 0 and alarm
// - sync-restore: failed sync reloads stored position
// - log position changes and unconfirmed preselections
// - power-up modes three, restore default; events off
// - step edge advances, wraps top to 1
// - stepping activity restarts time-out
// - word out of range: no change, alarm 3s
// - time-out 3.0 to 60.0 s, 0.1 s steps
`timescale 1ns/1ps
module mps_selector
	import mps_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic enable,
	input wire logic [2:0] fullRange,
	input wire logic [9:0] timeoutTenths,
	input wire logic stepConfirmMode,
	input wire logic wordConfirmMode,
	input wire logic [1:0] powerupMode,
	input wire logic eventsEnable,
	input wire logic powerCycle,
	input wire logic [2:0] storedPosition,
	input wire logic stepInput,
	input wire logic stepConfirmInput,
	input wire logic word_bit0,
	input wire logic word_bit1,
	input wire logic word_bit2,
	input wire logic word_confirm_input,
	output logic [6:0] positionOut,
	output logic [2:0] appliedPosition_q,
	output logic saveStrobe_q,
	output logic stepping_confirm_alarm,
	output logic word_confirm_alarm,
	output logic range_alarm,
	output logic powerup_position_alarm,
	output logic eventValid_q,
	output mps_event_t eventData_q
);
	logic [3:0] rawIn;
	logic [3:0] syncIn;
	logic [3:0] prevIn_q;
	logic [2:0] wordNow;
	logic stepRise;
	logic stepAckRise;
	logic wordAckRise;
	logic wordChange;
	logic pwrCycRise;
	logic [2:0] top;
	logic [9:0] timeoutEff;
	logic [31:0] tickCnt_q;
	logic tick_q;
	logic [9:0] toCnt_q;
	logic toExpire;
	mps_state_t state_q;
	logic [2:0] presel_q;
	logic [1:0] pwrCnt_q;
	logic pwrHold_q;
	logic stpAlarmTrig;
	logic bitAlarmTrig;
	logic rngAlarmTrig;
	logic applyNow;
	logic [2:0] applyPos;
	logic pwrAlarmSet;
	logic pwrAlarmClr;
	logic [1:0] puMode;
	logic stpAlarmOut;
	logic bitAlarmOut;
	logic rngAlarmOut;

	assign rawIn = {powerCycle, word_confirm_input, stepConfirmInput, stepInput};
	mps_sync #(.W(4)) ctrlSync (
		.mclk(mclk),
		.reset(reset),
		.din(rawIn),
		.dout(syncIn)
	);
	mps_sync #(.W(3)) wordSync (
		.mclk(mclk),
		.reset(reset),
		.din({word_bit2, word_bit1, word_bit0}),
		.dout(wordNow)
	);

	logic [2:0] wordPrev_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prevIn_q <= '0;
			wordPrev_q <= '0;
		end else begin
			prevIn_q <= syncIn;
			wordPrev_q <= wordNow;
		end
	end
	assign stepRise = syncIn[0] & ~prevIn_q[0];
	assign stepAckRise = syncIn[1] & ~prevIn_q[1];
	assign wordAckRise = syncIn[2] & ~prevIn_q[2];
	assign pwrCycRise = syncIn[3] & ~prevIn_q[3];
	assign wordChange = wordNow != wordPrev_q;

	// out-of-range settings fall back to documented limits
	assign top = (fullRange == POS_NONE) ? TOP_DEFAULT : fullRange;
	assign timeoutEff = (timeoutTenths < TIMEOUT_MIN) ? TIMEOUT_MIN :
		(timeoutTenths > TIMEOUT_MAX) ? TIMEOUT_MAX : timeoutTenths;
	assign puMode = (powerupMode == MPS_PU_SYNC || powerupMode == MPS_PU_SYNC_RESTORE) ?
		powerupMode : MPS_PU_RESTORE;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tickCnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tickCnt_q == TICK_LEN - 1) begin
			tickCnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// activity on the owning path reloads the window
	logic restartTo;
	assign restartTo = (state_q == MPS_STEP && stepRise) || (state_q == MPS_WORD && wordChange) ||
		(state_q == MPS_IDLE && (stepRise || (wordChange && wordNow != POS_NONE)));
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			toCnt_q <= '0;
		end else if (restartTo) begin
			toCnt_q <= timeoutEff;
		end else if (tick_q && toCnt_q != '0) begin
			toCnt_q <= toCnt_q - 10'h001;
		end
	end
	assign toExpire = tick_q && toCnt_q == 10'h001 && !restartTo;

	// main sequencer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= MPS_PWRUP;
			presel_q <= POS_NONE;
			pwrCnt_q <= '0;
		end else if (!enable) begin
			state_q <= MPS_IDLE;
			presel_q <= POS_NONE;
		end else begin
			case (state_q)
				MPS_PWRUP: begin
					if (puMode == MPS_PU_RESTORE) begin
						state_q <= MPS_IDLE;
					end else if (pwrCycRise) begin
						pwrCnt_q <= pwrCnt_q + 2'h1;
						if (pwrCnt_q + 2'h1 >= PWRUP_CYCLES) begin
							state_q <= MPS_IDLE;
						end
					end
				end
				MPS_IDLE: begin
					if (stepRise) begin
						state_q <= MPS_STEP;
						presel_q <= (appliedPosition_q >= top) ? POS_FIRST : appliedPosition_q + 3'h1;
					end else if (wordChange && wordNow != POS_NONE) begin
						state_q <= MPS_WORD;
						presel_q <= wordNow;
					end
				end
				MPS_STEP: begin
					if (stepRise) begin
						presel_q <= (presel_q >= top) ? POS_FIRST : presel_q + 3'h1;
					end else if (stepConfirmMode && stepAckRise) begin
						state_q <= MPS_IDLE;
					end else if (toExpire) begin
						state_q <= MPS_IDLE;
					end
				end
				MPS_WORD: begin
					if (wordChange) begin
						// a rest code mid-sequence keeps the pending choice
						if (wordNow != POS_NONE) begin
							presel_q <= wordNow;
						end
					end else if (wordConfirmMode && wordAckRise) begin
						state_q <= MPS_IDLE;
					end else if (toExpire) begin
						state_q <= MPS_IDLE;
					end
				end
				default: state_q <= MPS_IDLE;
			endcase
		end
	end

	// decide application and alarms
	always_comb begin
		applyNow = 1'b0;
		applyPos = presel_q;
		stpAlarmTrig = 1'b0;
		bitAlarmTrig = 1'b0;
		rngAlarmTrig = 1'b0;
		pwrAlarmSet = 1'b0;
		pwrAlarmClr = 1'b0;
		if (enable) begin
			case (state_q)
				MPS_PWRUP: begin
					if (puMode == MPS_PU_RESTORE) begin
						applyNow = 1'b1;
						if (storedPosition == POS_NONE || storedPosition > top) begin
							applyPos = POS_NONE;
							pwrAlarmSet = 1'b1;
						end else begin
							applyPos = storedPosition;
						end
					end else if (pwrCycRise && pwrCnt_q + 2'h1 >= PWRUP_CYCLES) begin
						applyNow = 1'b1;
						if (wordNow != POS_NONE && wordNow <= top) begin
							applyPos = wordNow;
							pwrAlarmClr = 1'b1;
						end else if (puMode == MPS_PU_SYNC_RESTORE && storedPosition != POS_NONE &&
							storedPosition <= top) begin
							applyPos = storedPosition;
							pwrAlarmClr = 1'b1;
						end else begin
							applyPos = POS_NONE;
						end
					end else begin
						applyNow = 1'b1;
						applyPos = POS_NONE;
						pwrAlarmSet = 1'b1;
					end
				end
				MPS_STEP: begin
					if (!stepRise && stepConfirmMode && stepAckRise) begin
						applyNow = 1'b1;
					end else if (!stepRise && toExpire) begin
						applyNow = !stepConfirmMode;
						stpAlarmTrig = stepConfirmMode;
					end
				end
				MPS_WORD: begin
					if (!wordChange && ((wordConfirmMode && wordAckRise) || (toExpire && !wordConfirmMode))) begin
						if (presel_q > top) begin
							rngAlarmTrig = 1'b1;
						end else begin
							applyNow = 1'b1;
						end
					end else if (!wordChange && toExpire) begin
						bitAlarmTrig = 1'b1;
					end
				end
				default: applyNow = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			appliedPosition_q <= POS_NONE;
			saveStrobe_q <= 1'b0;
			positionOut <= '0;
		end else begin
			saveStrobe_q <= 1'b0;
			if (applyNow) begin
				appliedPosition_q <= applyPos;
				saveStrobe_q <= applyPos != POS_NONE;
				// one-hot decode, position 0 drives nothing
				positionOut <= (applyPos == POS_NONE) ? 7'h00 : 7'(7'h01 << (applyPos - 3'h1));
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			powerup_position_alarm <= 1'b0;
		end else if (pwrAlarmSet || (applyNow && state_q == MPS_PWRUP && applyPos == POS_NONE)) begin
			powerup_position_alarm <= 1'b1;
		end else if (pwrAlarmClr || (applyNow && state_q != MPS_PWRUP)) begin
			powerup_position_alarm <= 1'b0;
		end
	end

	mps_alarm_timer stpTimer (
		.mclk(mclk),
		.reset(reset),
		.tick(tick_q),
		.trigger(stpAlarmTrig),
		.alarm(stpAlarmOut)
	);
	mps_alarm_timer bitTimer (
		.mclk(mclk),
		.reset(reset),
		.tick(tick_q),
		.trigger(bitAlarmTrig),
		.alarm(bitAlarmOut)
	);
	mps_alarm_timer rngTimer (
		.mclk(mclk),
		.reset(reset),
		.tick(tick_q),
		.trigger(rngAlarmTrig),
		.alarm(rngAlarmOut)
	);
	assign stepping_confirm_alarm = stpAlarmOut;
	assign word_confirm_alarm = bitAlarmOut;
	assign range_alarm = rngAlarmOut;

	// event log: position changes and missed confirmations
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			eventValid_q <= 1'b0;
			eventData_q <= '0;
		end else begin
			eventValid_q <= 1'b0;
			if (eventsEnable) begin
				if (applyNow && applyPos != POS_NONE && applyPos != appliedPosition_q) begin
					eventValid_q <= 1'b1;
					eventData_q <= '{code: MPS_EV_POS, pos: applyPos};
				end else if (stpAlarmTrig) begin
					eventValid_q <= 1'b1;
					eventData_q <= '{code: MPS_EV_STP_ALARM, pos: presel_q};
				end else if (bitAlarmTrig) begin
					eventValid_q <= 1'b1;
					eventData_q <= '{code: MPS_EV_BIT_ALARM, pos: presel_q};
				end
			end
		end
	end
endmodule : mps_selector

//--- src/mps_pkg.sv
package mps_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	// time tick of 0.1 s derived from the system clock
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam logic [9:0] TIMEOUT_MIN = 10'h01e;
	localparam logic [9:0] TIMEOUT_MAX = 10'h258;
	localparam logic [9:0] TIMEOUT_DEFAULT = 10'h032;
	localparam int unsigned ALARM_S = 3;
	localparam logic [9:0] ALARM_TICKS = 10'h01e;
	localparam logic [2:0] TOP_DEFAULT = 3'h7;
	localparam logic [2:0] POS_NONE = 3'h0;
	localparam logic [2:0] POS_FIRST = 3'h1;
	localparam logic [1:0] PWRUP_CYCLES = 2'h2;
	localparam logic EVENTS_DEFAULT = 1'b0;

	typedef enum logic [1:0] {
		MPS_PU_RESTORE = 2'b00,
		MPS_PU_SYNC = 2'b01,
		MPS_PU_SYNC_RESTORE = 2'b10
	} mps_pwrup_t;

	typedef enum logic [1:0] {
		MPS_IDLE = 2'b00,
		MPS_STEP = 2'b01,
		MPS_WORD = 2'b10,
		MPS_PWRUP = 2'b11
	} mps_state_t;

	typedef enum logic [3:0] {
		MPS_EV_NONE = 4'h0,
		MPS_EV_POS = 4'h1,
		MPS_EV_STP_ALARM = 4'h8,
		MPS_EV_BIT_ALARM = 4'h9
	} mps_ev_code_t;

	typedef struct packed {
		mps_ev_code_t code;
		logic [2:0] pos;
	} mps_event_t;
endpackage : mps_pkg

//--- src/mps_sync.sv
`timescale 1ns/1ps
module mps_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : mps_sync

//--- src/mps_alarm_timer.sv
`timescale 1ns/1ps
module mps_alarm_timer
	import mps_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic tick,
	input wire logic trigger,
	output logic alarm
);
	logic [9:0] cnt_q;
	// retrigger restarts the full hold time
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
			alarm <= 1'b0;
		end else begin
			if (trigger) begin
				cnt_q <= ALARM_TICKS;
				alarm <= 1'b1;
			end else if (tick && cnt_q != '0) begin
				cnt_q <= cnt_q - 10'h001;
				alarm <= (cnt_q != 10'h001);
			end
		end
	end
endmodule : mps_alarm_timer

//--- tb/mps_buttons.sv
`timescale 1ns/1ps
module mps_buttons (
	input wire logic mclk,
	input wire logic [2:0] press,
	output logic [2:0] btn
);
	// a press holds the button 8 clocks so the 2-flop sync cannot miss it
	logic [3:0] held_q [3] = '{default: 4'h0};
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (press[i]) begin
				held_q[i] <= 4'h8;
			end else if (held_q[i] != 4'h0) begin
				held_q[i] <= held_q[i] - 4'h1;
			end
		end
	end
	// a released button reads low, as a pulled-down contact would
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			btn[i] = held_q[i] != 4'h0;
		end
	end
endmodule : mps_buttons

//--- tb/mps_selector_chk.sv
`timescale 1ns/1ps
module mps_selector_chk
	import mps_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic eventsEnable,
	input wire logic [6:0] positionOut,
	input wire logic [2:0] appliedPosition_q,
	input wire logic saveStrobe_q,
	input wire logic stepping_confirm_alarm,
	input wire logic word_confirm_alarm,
	input wire logic eventValid_q,
	input wire mps_event_t eventData_q
);
	localparam int unsigned AL_MIN = 29 * TICK_LEN;
	localparam int unsigned AL_MAX = 30 * TICK_LEN + 1;
	logic [31:0] stepLen_q;
	logic [31:0] wordLen_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// 3 s is far beyond any repetition, so alarm widths are counted
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stepLen_q <= 32'h0;
			wordLen_q <= 32'h0;
		end else begin
			stepLen_q <= stepping_confirm_alarm ? stepLen_q + 32'h1 : 32'h0;
			wordLen_q <= word_confirm_alarm ? wordLen_q + 32'h1 : 32'h0;
		end
	end
	sequence applied_s;
		$changed(appliedPosition_q) && appliedPosition_q != POS_NONE;
	endsequence
	onehot_out_a: assert property ($onehot0(positionOut))
		else $error("several position outputs");
	zero_dark_a: assert property (appliedPosition_q == POS_NONE |-> positionOut == 7'h0)
		else $error("output lit at position 0");
	save_apply_a: assert property (applied_s |-> saveStrobe_q)
		else $error("apply without store strobe");
	save_pulse_a: assert property (saveStrobe_q |=> !saveStrobe_q)
		else $error("store strobe too long");
	event_pulse_a: assert property (eventValid_q |=> !eventValid_q)
		else $error("event strobe too long");
	events_off_a: assert property (eventValid_q |-> eventsEnable || $past(eventsEnable))
		else $error("event while logging off");
	event_pos_a: assert property (eventValid_q && eventData_q.code == MPS_EV_POS
		|-> eventData_q.pos == appliedPosition_q && appliedPosition_q != POS_NONE)
		else $error("event position mismatch");
	alarm_max_a: assert property (stepLen_q <= AL_MAX && wordLen_q <= AL_MAX)
		else $error("alarm held too long");
	step_min_a: assert property ($fell(stepping_confirm_alarm) |-> stepLen_q >= AL_MIN)
		else $error("stepping alarm too short");
	word_min_a: assert property ($fell(word_confirm_alarm) |-> wordLen_q >= AL_MIN)
		else $error("word alarm too short");
endmodule : mps_selector_chk

//--- tb/mps_selector_tb.sv
`timescale 1ns/1ps
module mps_selector_tb
	import mps_pkg::*;
;
	logic mclk = 1'b0, reset = 1'b1, enable = 1'b1, powerCycle = 1'b0;
	logic stepConfirmMode = 1'b0, wordConfirmMode = 1'b0, eventsEnable = 1'b0;
	logic [2:0] fullRange = 3'h5, storedPosition = 3'h3, word = 3'h0, press = 3'h0, btn, seen;
	logic [9:0] timeoutTenths = 10'h01e;
	logic [1:0] powerupMode = 2'h0;
	logic [6:0] positionOut;
	logic [2:0] appliedPosition_q;
	logic saveStrobe_q, stepping_confirm_alarm, word_confirm_alarm, range_alarm;
	logic powerup_position_alarm, eventValid_q;
	mps_event_t eventData_q;
	logic [31:0] rng = 32'h09252cb2;
	int num_errors = 0, total_checks = 0, expPos, c;
	// expected log entries in order, code * 8 + position
	int evQ[$];
	int puMode[5] = '{0, 0, 1, 1, 2};
	int puSt[5] = '{3, 6, 3, 3, 3};
	int puW[5] = '{0, 0, 5, 0, 0};
	int puExp[5] = '{3, 0, 5, 0, 3};
	mps_selector #(.TICK_LEN(10)) dut (
		.mclk, .reset, .enable, .fullRange, .timeoutTenths, .stepConfirmMode, .wordConfirmMode,
		.powerupMode, .eventsEnable, .powerCycle, .storedPosition, .stepInput(btn[0]),
		.stepConfirmInput(btn[1]), .word_bit0(word[0]), .word_bit1(word[1]), .word_bit2(word[2]),
		.word_confirm_input(btn[2]), .positionOut, .appliedPosition_q, .saveStrobe_q,
		.stepping_confirm_alarm, .word_confirm_alarm, .range_alarm, .powerup_position_alarm,
		.eventValid_q, .eventData_q
	);
	mps_buttons pads (.mclk, .press, .btn);
	always #2.5 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cpos(int e);
		chk({5'h0, appliedPosition_q}, 8'(e));
		chk({1'b0, positionOut}, e != 0 ? 8'h1 << (e - 1) : 8'h0);
	endtask : cpos
	// alarms are collected over the whole wait since their start edge is not pinned
	task automatic run(int n);
		seen = 3'h0;
		repeat (n) begin
			@(negedge mclk);
			seen |= {range_alarm, word_confirm_alarm, stepping_confirm_alarm};
		end
	endtask : run
	task automatic ev(int code, int pos);
		evQ.push_back(code * 8 + pos);
	endtask : ev
	task automatic push(int b);
		@(negedge mclk);
		press[b] = 1'b1;
		@(negedge mclk);
		press[b] = 1'b0;
	endtask : push
	initial begin
		#400us;
		num_errors++;
		end_sim();
	end
	// every logged event must be the next one the model expects
	always @(negedge mclk) begin
		if (!reset && eventValid_q) begin
			chk(8'(eventData_q), evQ.size() != 0 ? 8'(evQ.pop_front()) : 8'hff);
		end
	end
	initial begin
		for (int i = 0; i < 5; i++) begin
			reset = 1'b1;
			powerupMode = 2'(puMode[i]);
			storedPosition = 3'(puSt[i]);
			word = 3'(puW[i]);
			run(4);
			reset = 1'b0;
			run(20);
			if (puMode[i] != 0) begin
				cpos(0);
				chk(powerup_position_alarm, 8'h1);
			end
			repeat (2) begin
				powerCycle = 1'b1;
				run(5);
				powerCycle = 1'b0;
				run(5);
			end
			run(20);
			cpos(puExp[i]);
			chk(powerup_position_alarm, 8'(puExp[i] == 0));
		end
		$display("test powerup done");
		expPos = 3;
		eventsEnable = 1'b1;
		ev(1, 2);
		for (int k = 0; k < 4; k++) begin
			push(0);
			run(40);
		end
		run(160);
		cpos(3);
		run(200);
		cpos(2);
		stepConfirmMode = 1'b1;
		ev(1, 3);
		push(0);
		run(40);
		push(1);
		run(20);
		cpos(3);
		ev(8, 4);
		push(0);
		run(650);
		cpos(3);
		chk(8'(seen[0]), 8'h1);
		stepConfirmMode = 1'b0;
		push(1);
		run(20);
		cpos(3);
		ev(1, 4);
		push(0);
		run(20);
		word = 3'h1;
		run(400);
		cpos(4);
		$display("test stepping done");
		expPos = 4;
		for (int k = 0; k < 12; k++) begin
			c = k < 8 ? k : int'(rnd() % 32'h8);
			if (c != 0 && c <= 5 && c != expPos) begin
				ev(1, c);
			end
			word = 3'h0;
			run(20);
			word = 3'(c);
			run(650);
			if (c != 0 && c <= 5) begin
				expPos = c;
			end
			cpos(expPos);
			chk(8'(seen[2]), 8'(c > 5));
		end
		$display("test word done");
		wordConfirmMode = 1'b1;
		word = 3'h0;
		run(20);
		c = expPos % 5 + 1;
		ev(1, c);
		ev(9, c % 5 + 1);
		word = 3'(c);
		run(40);
		push(0);
		run(20);
		push(1);
		run(20);
		cpos(expPos);
		push(2);
		run(20);
		cpos(c);
		word = 3'h0;
		run(20);
		word = 3'(c % 5 + 1);
		run(650);
		cpos(c);
		chk(8'(seen[1]), 8'h1);
		chk(8'(evQ.size()), 8'h0);
		$display("test confirm done");
		end_sim();
	end
endmodule : mps_selector_tb
bind mps_selector mps_selector_chk #(.TICK_LEN(TICK_LEN)) chk (.mclk, .reset, .eventsEnable,
	.positionOut, .appliedPosition_q, .saveStrobe_q, .stepping_confirm_alarm,
	.word_confirm_alarm, .eventValid_q, .eventData_q);
